// File: verilog/stcg_top.sv
/*
 * serial transfer clock generator: apb registers, baud generator,
 * synchronous shift clock in and out, uart clock select and the
 * divide by sixteen bit counter.
 * assumes presTick and timerFf come from logic on core_clk, and
 * sclkIn is a pin from outside the clock domain.
 */
// What this block does
// - fractional division only in uart mode
// - n 1..16, fractional n 2..15, k 1..15
// - mode field picks synchronous or uart clocking
// - driven shift clock is baud output halved
// - external shift clock on chosen edge
// - uart bit spans sixteen transfer clocks
// - uart source: timer, baud, sysclk, external
// - timer source period is two toggles
// - baud input is prescaler /2,/8,/32,/128
`timescale 1ns/100ps
`default_nettype none
`include "stcg_map.svh"

module stcg_top
   import stcg_pkg::*;
#(
   parameter int OVS = `STCG_UART_OVS // transfer clocks per uart bit
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire stcg_apb_req_t apbReq,
   output var stcg_apb_rsp_t apbRsp,
   input wire logic [3:0] presTick,
   input wire logic timerFf,
   input wire logic sclkIn,
   output var logic sclkOut,
   output var logic sclkOe,
   output var logic xferTick,
   output var logic shiftTick,
   output var logic uartBitTick
);

   // the bit counter is four bits wide
   if (OVS < 2 || OVS > 16) begin : g_chk
      $error("OVS must lie between 2 and 16");
   end

   localparam logic [3:0] OVS_LAST = 4'(OVS - 1); // last count of a bit

   stcg_state_t r_q; // registered state
   stcg_state_t r_d; // next state
   logic baudIn; // selected prescaler tap
   logic baudTick; // baud generator output
   logic fracActive; // fractional division in force
   logic isUart; // uart mode selected
   logic ioOut; // synchronous mode, shift clock driven out
   logic ioIn; // synchronous mode, shift clock from pin
   logic extRise; // synchronised pin rising edge
   logic extFall; // synchronised pin falling edge
   logic timerRise; // one timer flip-flop rise per two toggles
   logic srcTick; // selected uart transfer clock
   logic setup; // apb setup phase
   logic access; // apb access phase

   // true for an aligned offset that holds a register
   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == `STCG_OFF_BAUD_CTRL) ||
                 (a == `STCG_OFF_BAUD_FRAC) ||
                 (a == `STCG_OFF_MODE0) ||
                 (a == `STCG_OFF_CTRL) ||
                 (a == `STCG_OFF_STATUS);
   endfunction

   // mode decode and legality of the fractional setting
   always_comb begin
      isUart = r_q.mode0.serialModeField == STCG_UART;
      ioOut = !isUart && !r_q.ctrl.ioInput;
      ioIn = !isUart && r_q.ctrl.ioInput;
      fracActive = isUart && r_q.baudCtrl.fracEn &&
                   r_q.baudCtrl.divN >= `STCG_FRAC_NMIN &&
                   r_q.baudCtrl.divN <= `STCG_FRAC_NMAX &&
                   r_q.fracK >= `STCG_FRAC_KMIN;
      baudIn = presTick[r_q.baudCtrl.baudInputSelect];
   end

   // baud rate generator output divider
   stcg_baud_div u_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .inTick(baudIn),
      .divN(r_q.baudCtrl.divN),
      .fracEn(fracActive),
      .fracK(r_q.fracK),
      .outTick(baudTick)
   );

   // edges of the synchronised pin and of the timer flip-flop
   always_comb begin
      extRise = r_q.extSync2 && !r_q.extPrev;
      extFall = !r_q.extSync2 && r_q.extPrev;
      timerRise = timerFf && !r_q.timerPrev;
      setup = apbReq.psel && !apbReq.penable;
      access = apbReq.psel && apbReq.penable;
   end

   // uart transfer clock source select
   always_comb begin
      unique case (r_q.mode0.uartClockSelect)
         STCG_SRC_TIMER: srcTick = timerRise;
         STCG_SRC_BAUD: srcTick = baudTick;
         STCG_SRC_SYS: srcTick = 1'b1;
         STCG_SRC_EXT: srcTick = extRise;
      endcase
   end

   // next state: registers, synchroniser, clock paths, read data
   always_comb begin
      r_d = r_q;
      // pin synchroniser, first stage feeds only the second
      r_d.extSync1 = sclkIn;
      r_d.extSync2 = r_q.extSync1;
      r_d.extPrev = r_q.extSync2;
      r_d.timerPrev = timerFf;
      r_d.xferTick = 1'b0;
      r_d.shiftTick = 1'b0;
      r_d.bitTick = 1'b0;
      if (isUart) begin
         // count sixteen transfer clocks per serial bit
         r_d.xferTick = srcTick;
         if (srcTick) begin
            if (r_q.ovsCnt == OVS_LAST) begin
               r_d.ovsCnt = 4'h0;
               r_d.bitTick = 1'b1;
            end else begin
               r_d.ovsCnt = r_q.ovsCnt + 4'h1;
            end
         end
      end else if (ioOut) begin
         // driven clock toggles once per baud tick; shift on rise
         r_d.ovsCnt = 4'h0;
         r_d.xferTick = baudTick;
         if (baudTick) begin
            r_d.sclkLevel = !r_q.sclkLevel;
            r_d.shiftTick = !r_q.sclkLevel;
         end
      end else begin
         // external clock; edge set by the edge select bit
         r_d.ovsCnt = 4'h0;
         r_d.sclkLevel = 1'b0;
         r_d.xferTick = extRise || extFall;
         r_d.shiftTick = r_q.ctrl.edgeFall ? extFall : extRise;
      end
      // apb setup: latch read data and the unmapped flag
      if (setup) begin
         r_d.slverr = !isMapped(apbReq.paddr);
         r_d.rdata = 32'h0;
         unique case (apbReq.paddr)
            `STCG_OFF_BAUD_CTRL: r_d.rdata[`STCG_BC_MSB:0] = r_q.baudCtrl;
            `STCG_OFF_BAUD_FRAC: r_d.rdata[`STCG_K_MSB:0] = r_q.fracK;
            `STCG_OFF_MODE0: r_d.rdata[`STCG_M0_MSB:0] = r_q.mode0;
            `STCG_OFF_CTRL: r_d.rdata[`STCG_CR_MSB:0] = r_q.ctrl;
            `STCG_OFF_STATUS: r_d.rdata[`STCG_ST_MSB:0] =
               {r_q.extSync2, r_q.ovsCnt, fracActive, r_q.sclkLevel};
            default: r_d.rdata = 32'h0; // unmapped reads zero
         endcase
      end
      // apb access: writes take effect, zero wait states
      if (access && apbReq.pwrite) begin
         unique case (apbReq.paddr)
            `STCG_OFF_BAUD_CTRL: r_d.baudCtrl =
               stcg_baud_ctrl_t'(apbReq.pwdata[`STCG_BC_MSB:0]);
            `STCG_OFF_BAUD_FRAC: r_d.fracK = apbReq.pwdata[`STCG_K_MSB:0];
            `STCG_OFF_MODE0: r_d.mode0 =
               stcg_mode0_t'(apbReq.pwdata[`STCG_M0_MSB:0]);
            `STCG_OFF_CTRL: r_d.ctrl =
               stcg_ctrl_t'(apbReq.pwdata[`STCG_CR_MSB:0]);
            default: r_d.ctrl = r_q.ctrl; // status and holes ignore writes
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // outputs
   always_comb begin
      apbRsp.prdata = r_q.rdata;
      apbRsp.pready = 1'b1;
      apbRsp.pslverr = r_q.slverr && access;
      sclkOut = r_q.sclkLevel;
      sclkOe = ioOut;
      xferTick = r_q.xferTick;
      shiftTick = r_q.shiftTick;
      uartBitTick = r_q.bitTick;
   end

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_io_no_fraction: assert property (!isUart |-> !fracActive)
      else $error("fractional division active in synchronous mode");
   a_frac_limits: assert property (fracActive |->
      r_q.baudCtrl.divN inside {[2:15]} && r_q.fracK != 4'h0)
      else $error("fractional division with illegal n or k");
   a_pin_drive: assert property ((isUart || ioIn) == !sclkOe)
      else $error("shift clock drive does not follow mode");
   a_half_baud: assert property (
      (ioOut && baudTick) ##1 ioOut |-> sclkOut != $past(sclkOut))
      else $error("driven shift clock did not toggle on baud tick");
   a_ext_edge: assert property ((ioIn && !r_q.ctrl.edgeFall && extRise) ||
      (ioIn && r_q.ctrl.edgeFall && extFall) |=> shiftTick)
      else $error("external edge did not shift");
   a_bit_sixteen: assert property (uartBitTick |->
      $past(r_q.ovsCnt) == OVS_LAST && $past(srcTick))
      else $error("uart bit tick off the sixteenth clock");
   a_sys_source: assert property (
      isUart && r_q.mode0.uartClockSelect == STCG_SRC_SYS |=> xferTick)
      else $error("system clock source missed a cycle");
   a_timer_rise: assert property ((isUart &&
      r_q.mode0.uartClockSelect == STCG_SRC_TIMER) ##1 xferTick |->
      $past(timerFf) && !$past(r_q.timerPrev))
      else $error("timer source tick without a timer rise");
   a_apb_unmapped: assert property (access &&
      !isMapped(apbReq.paddr) |-> apbRsp.pslverr && apbRsp.pready)
      else $error("unmapped access not refused");

   c_io_out_shift: cover property (ioOut && shiftTick);
   c_ext_shift: cover property (ioIn && r_q.ctrl.edgeFall && shiftTick);
   c_uart_bit: cover property (isUart && uartBitTick);
   c_timer_bit: cover property (isUart &&
      r_q.mode0.uartClockSelect == STCG_SRC_TIMER && uartBitTick);

endmodule
`default_nettype wire

// File: shared/stcg_map.svh
/*
 * constants of the transfer clock generator: register offsets,
 * field limits and timing counts.
 * assumes inclusion by bare name from package and design files.
 */
`ifndef STCG_MAP_SVH
`define STCG_MAP_SVH

// register byte offsets on the apb bus
`define STCG_OFF_BAUD_CTRL 12'h000
`define STCG_OFF_BAUD_FRAC 12'h004
`define STCG_OFF_MODE0 12'h008
`define STCG_OFF_CTRL 12'h00c
`define STCG_OFF_STATUS 12'h010

// field msb positions inside the 32-bit data word
`define STCG_BC_MSB 6
`define STCG_K_MSB 3
`define STCG_M0_MSB 2
`define STCG_CR_MSB 1
`define STCG_ST_MSB 6

// divider figures
`define STCG_DIV_ZERO 4'h0
`define STCG_DIV_MAX 5'h10
`define STCG_FRAC_NMIN 4'h2
`define STCG_FRAC_NMAX 4'hf
`define STCG_FRAC_KMIN 4'h1
`define STCG_FRAC_GROUP 5'h10

// uart oversampling: one serial bit per sixteen transfer clocks
`define STCG_UART_OVS 16

`endif

// File: shared/stcg_pkg.sv
/*
 * types of the transfer clock generator: register layouts,
 * mode and source codes, apb carriers and the state records.
 * assumes stcg_map.svh is on the include path.
 */
`include "stcg_map.svh"

package stcg_pkg;

   // serial mode field: synchronous or uart
   typedef enum logic {STCG_IO, STCG_UART} stcg_mode_t;

   // uart clock select field
   typedef enum logic [1:0] {
      STCG_SRC_TIMER, STCG_SRC_BAUD, STCG_SRC_SYS, STCG_SRC_EXT
   } stcg_src_t;

   // baud_ctrl_reg: fraction enable, input select, divisor (0 = 16)
   typedef struct packed {
      logic fracEn;
      logic [1:0] baudInputSelect;
      logic [3:0] divN;
   } stcg_baud_ctrl_t;

   // serial_mode_reg0: mode field over clock select
   typedef struct packed {
      stcg_mode_t serialModeField;
      stcg_src_t uartClockSelect;
   } stcg_mode0_t;

   // serial_control_reg: edge select over direction (1 = clock in)
   typedef struct packed {
      logic edgeFall;
      logic ioInput;
   } stcg_ctrl_t;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } stcg_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } stcg_apb_rsp_t;

   // baud divider state
   typedef struct packed {
      logic [4:0] cnt;
      logic [3:0] phase;
      logic tick;
   } stcg_div_st_t;

   // top level state
   typedef struct packed {
      stcg_baud_ctrl_t baudCtrl;
      logic [3:0] fracK;
      stcg_mode0_t mode0;
      stcg_ctrl_t ctrl;
      logic extSync1;
      logic extSync2;
      logic extPrev;
      logic timerPrev;
      logic sclkLevel;
      logic [3:0] ovsCnt;
      logic xferTick;
      logic shiftTick;
      logic bitTick;
      logic [31:0] rdata;
      logic slverr;
   } stcg_state_t;

endpackage

// File: verilog/stcg_baud_div.sv
/*
 * baud rate generator output divider: integer divide by n or
 * fractional n + (16-k)/16, counted in input clock ticks.
 * assumes inTick is a one-cycle enable on core_clk and that the
 * caller only raises fracEn with legal n and k.
 */
`timescale 1ns/100ps
`default_nettype none
`include "stcg_map.svh"

module stcg_baud_div
   import stcg_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic inTick,
   input wire logic [3:0] divN,
   input wire logic fracEn,
   input wire logic [3:0] fracK,
   output var logic outTick
);

   stcg_div_st_t s_q; // registered state
   stcg_div_st_t s_d; // next state
   logic [4:0] len; // input ticks in the current output period

   // period length and counter advance
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      // a divisor field of zero stands for sixteen
      if (divN == `STCG_DIV_ZERO) begin
         len = `STCG_DIV_MAX;
      end else begin
         len = {1'b0, divN};
      end
      // first 16-k periods of each group of 16 are one tick longer
      if (fracEn && ({1'b0, s_q.phase} <
          (`STCG_FRAC_GROUP - {1'b0, fracK}))) begin
         len = len + 5'h01;
      end
      if (inTick) begin
         if (s_q.cnt + 5'h01 >= len) begin
            s_d.cnt = 5'h00;
            s_d.phase = s_q.phase + 4'h1; // wraps every 16 periods
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 5'h01;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign outTick = s_q.tick;

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_tick_from_input: assert property (outTick |-> $past(inTick))
      else $error("baud tick without input tick");
   a_count_in_range: assert property (s_q.cnt < `STCG_DIV_MAX)
      else $error("baud counter ran past sixteen");
   c_frac_tick: cover property (fracEn && outTick);

endmodule
`default_nettype wire

// File: sim/stcg_sclk_partner.sv
/*
 * partner model: external device that drives the shift clock pin.
 * assumes go is a one-cycle pulse on core_clk; the pin idles low.
 */
`timescale 1ns/100ps
`default_nettype none
module stcg_sclk_partner (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [7:0] nPer,
   input wire logic [7:0] halfCyc,
   output var logic sclkDrv
);
   logic [7:0] hc; // cycles into the half period
   logic [8:0] left; // half periods still to send
   initial begin
      sclkDrv = 1'b0;
      hc = 8'h00;
      left = 9'h000;
   end
   // clock runs only inside a frame and stands still between frames
   always @(posedge core_clk) begin
      if (go) begin
         left <= {nPer, 1'b0};
         hc <= 8'h00;
      end else if (left != 9'h000) begin
         if (hc == halfCyc - 8'h01) begin
            sclkDrv <= ~sclkDrv;
            left <= left - 9'h001;
            hc <= 8'h00;
         end else begin
            hc <= hc + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/tb_serial_transfer_clock_gen.sv
/*
 * self-checking bench of the transfer clock generator.
 * assumes the partner model drives the pin while sclkOe is low.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_transfer_clock_gen;
   import stcg_pkg::*;
   localparam int OVS = 4; // short uart bit for quick counts
   logic core_clk, nrst, timerFf, pGo, sclkDrv, pinLvl, err;
   logic sclkOut, sclkOe, xferTick, shiftTick, uartBitTick;
   stcg_apb_req_t apbReq;
   stcg_apb_rsp_t apbRsp;
   logic [3:0] presTick;
   logic [7:0] pc = 8'h00; // prescaler model count
   logic [31:0] rd; // last read data
   int error_cnt = 0;
   int checks = 0;
   int xc, sc, bc; // tick counts of the last window
   assign pinLvl = sclkOe ? sclkOut : sclkDrv; // shared pin level
   stcg_top #(.OVS(OVS)) u_dut (.core_clk(core_clk), .nrst(nrst),
      .apbReq(apbReq), .apbRsp(apbRsp), .presTick(presTick),
      .timerFf(timerFf), .sclkIn(pinLvl), .sclkOut(sclkOut),
      .sclkOe(sclkOe), .xferTick(xferTick), .shiftTick(shiftTick),
      .uartBitTick(uartBitTick));
   stcg_sclk_partner u_part (.core_clk(core_clk), .go(pGo),
      .nPer(8'h14), .halfCyc(8'h06), .sclkDrv(sclkDrv));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // prescaler taps /2 /8 /32 /128 and a timer flip-flop of period 8
   always @(posedge core_clk) begin
      pc <= pc + 8'h01;
      presTick <= {pc[6:0] == 7'h00, pc[4:0] == 5'h00,
         pc[2:0] == 3'h0, pc[0] == 1'b0};
      timerFf <= pc[2];
   end
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   // one apb transfer, entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      apbReq <= '{1'b1, 1'b0, wr, a, d};
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      // wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge core_clk);
      end while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // count ticks over n cycles; optionally check pin level at shifts
   task automatic win(input int n, input logic cl, input logic el);
      xc = 0;
      sc = 0;
      bc = 0;
      repeat (n) begin
         @(negedge core_clk);
         xc += int'(xferTick === 1'b1);
         sc += int'(shiftTick === 1'b1);
         bc += int'(uartBitTick === 1'b1);
         if (cl && shiftTick === 1'b1) chk("shift level", el, pinLvl);
      end
      @(posedge core_clk);
   endtask
   task automatic t_regs;
      logic [11:0] ad[6] = '{12'h000, 12'h004, 12'h008, 12'h00c,
         12'h014, 12'h002};
      logic [31:0] ex[6] = '{32'h7f, 32'hf, 32'h7, 32'h3, 32'h0, 32'h0};
      chk("reset oe", 1, sclkOe);
      chk("reset sclk", 0, sclkOut);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ad[i], 32'h0);
         chk("reset value", 0, rd);
         apb(1'b1, ad[i], 32'hffffffff);
         apb(1'b0, ad[i], 32'h0);
         chk("readback", ex[i], rd);
         chk("slverr", i > 3, err);
      end
      apb(1'b1, 12'h010, 32'h0);
      chk("status write err", 0, err);
   endtask
   task automatic t_uart_sys;
      apb(1'b1, 12'h008, 32'h6);
      win(64, 1'b0, 1'b0);
      chk("sys xfer", 64, xc);
      chk("uart bit", 64 / OVS, bc);
   endtask
   task automatic t_baud;
      // stimulus also sets fracEn with k=0 and with n=1; both fall back to integer n
      logic [31:0] bv[7] = '{'h00, 'h12, 'h22, 'h31,
         'h42, 'h42, 'h41};
      logic [31:0] kv[7] = '{0, 0, 0, 0, 'hc, 0, 1};
      int wv[7] = '{512, 512, 512, 512, 720, 720, 720};
      int ev[7] = '{16, 32, 8, 4, 160, 180, 360};
      apb(1'b1, 12'h008, 32'h5);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 12'h000, bv[i]);
         apb(1'b1, 12'h004, kv[i]);
         win(300, 1'b0, 1'b0);
         win(wv[i], 1'b0, 1'b0);
         chk("baud xfer", ev[i], xc);
      end
   endtask
   task automatic t_timer;
      apb(1'b1, 12'h008, 32'h4);
      win(64, 1'b0, 1'b0);
      chk("timer xfer", 8, xc);
   endtask
   task automatic t_io_out;
      apb(1'b1, 12'h000, 32'h42);
      apb(1'b1, 12'h004, 32'hc);
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00c, 32'h2);
      win(100, 1'b0, 1'b0);
      win(512, 1'b1, 1'b1);
      chk("out shift", 64, sc);
      chk("out xfer", 128, xc);
      chk("out oe", 1, sclkOe);
   endtask
   // shift clock from the partner, sampled on the chosen edge
   task automatic t_io_in(input logic fall);
      apb(1'b1, 12'h00c, {30'h0, fall, 1'b1});
      win(20, 1'b0, 1'b0);
      chk("in oe", 0, sclkOe);
      pGo <= 1'b1;
      @(posedge core_clk);
      pGo <= 1'b0;
      win(300, 1'b1, ~fall);
      chk("in shift", 20, sc);
      chk("in xfer", 40, xc);
   endtask
   task automatic t_uart_ext;
      apb(1'b1, 12'h008, 32'h7);
      pGo <= 1'b1;
      @(posedge core_clk);
      pGo <= 1'b0;
      win(300, 1'b0, 1'b0);
      chk("ext xfer", 20, xc);
      chk("ext bit", 20 / OVS, bc);
      chk("uart oe", 0, sclkOe);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog cuts a hang short
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      pGo = 1'b0;
      apbReq = '0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_uart_sys();
      t_baud();
      t_timer();
      t_io_out();
      t_io_in(1'b0);
      t_io_in(1'b1);
      t_uart_ext();
      end_sim();
   end
endmodule
`default_nettype wire
